/* core/i2c_seq_consts.svh */
// Purpose: offsets, field positions, reset values and timing for the i2c sequencer
// Assumes: 8-bit byte addresses on the register bus
// Notes: definitions only
`ifndef I2C_SEQ_CONSTS_SVH
`define I2C_SEQ_CONSTS_SVH
// register byte offsets
`define OFS_CTRL_ONE 8'h00
`define OFS_CTRL_TWO 8'h04
`define OFS_DATA 8'h08
`define OFS_STATUS 8'h0C
`define OFS_SLAVE_ADDR 8'h10
// first control register fields
`define C1_PORT_EN 5
`define C1_CLK_REL 4
`define C1_MASTER 3
// second control register fields
`define C2_GENERAL_CALL_ENABLE 7
`define C2_ACK_STATUS 6
`define C2_ACK_DATA_VALUE 5
`define C2_ACK_SEQUENCE_ENABLE 4
`define C2_RECEIVE_ENABLE_FIELD 3
`define C2_PEN 2
`define C2_REPEATED_START_ENABLE 1
`define C2_SEN 0
// status register fields
`define ST_EVENT 0
`define ST_GC 1
`define ST_BUSY 2
`define ST_FULL 3
// reset values and codes
`define CTRL_RESET 8'h00
`define ADDR_RESET 7'h00
`define GEN_CALL_ADDR 8'h00
// bit counts
`define LAST_DATA_BIT 4'h7
`define ACK_SLOT 4'h8
`define SLAVE_ACK_DONE 4'h9
// timing: quarter of a 100 kHz bit, rounded up to whole clocks
`define CLK_PERIOD_NS 10
`define QUARTER_NS 2500
`define QUARTER_CYC ((`QUARTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* core/i2c_seq_pkg.sv */
// Purpose: types shared by the i2c sequencer files
// Assumes: nothing
// Notes: master states gray coded along the usual path
`default_nettype none
package i2c_seq_pkg;
  typedef enum logic [2:0] {
    M_IDLE = 3'b000, M_START = 3'b001, M_TX = 3'b011, M_ACK = 3'b010,
    M_RX = 3'b110, M_RSTART = 3'b111, M_STOP = 3'b101
  } master_state_t;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00, S_ADDR = 2'b01, S_DATA = 2'b11, S_IGNORE = 2'b10
  } slave_state_t;
  // synchronised bus lines and their edges
  typedef struct packed {
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic sda_rise;
    logic sda_fall;
  } line_view_t;
endpackage
`default_nettype wire

/* core/i2c_sequence_control_fields.sv */
// Purpose: i2c sequence control fields with master engine and slave receive
// Assumes: APB slave, zero wait states, open-drain pins resolved outside
// Notes: scl is sampled by pclk; slave transmit is not handled
// Function
// - general call address interrupts only when enabled or when own address is zero
// - ack status shows slave acknowledge, 1 means none
// - ack data sets level driven in ack slot
// - ack sequence drives ack, then self clears
// - receive enable clocks in one master byte
// - stop enable drives stop, then self clears
// - repeated start enable drives repeated start
// - start enable drives start in master mode
// - same field enables stretching in slave mode
// - all fields readable and reset to zero, all but ack status writable
// - stretch holds scl low until clock release
// - nothing acts unless port enable set
//
// The implementer's own choices: the APB register port and the address map.
`include "i2c_seq_consts.svh"
`default_nettype none
module i2c_sequence_control_fields
  import i2c_seq_pkg::*;
#(
  parameter int unsigned QUARTER_CYCLES = `QUARTER_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // i2c pins
  input wire logic scl_in,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_o,
  output logic sda_oe,
  // event level
  output logic serial_event
);
  localparam logic [11:0] QLOAD = 12'(QUARTER_CYCLES - 1);

  line_view_t lines;
  master_state_t m_state_reg, launch_state;
  slave_state_t s_state_reg;
  logic [7:0] c2_reg, tx_byte_reg, rx_byte_reg, tx_shift_reg, rx_shift_reg, s_shift_reg;
  logic [6:0] slave_addr_reg;
  logic [1:0] phase_reg;
  logic [3:0] bit_reg, s_bits_reg;
  logic [11:0] qcnt_reg;
  logic [31:0] prdata_reg;
  logic port_en_reg, master_reg, clk_rel_reg, event_reg, gc_reg, full_reg, tx_pend_reg;
  logic scl_drv_reg, sda_drv_reg, s_ack_reg, s_took_reg, stretch_reg;
  logic master_en, slave_en, running, step, m_last, m_done, launch_ok;
  logic wr, rd, s_decide, s_hit, s_load, s_event, stretch_start;

  // address decode for the error answer; the read mux decodes on its own
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `OFS_CTRL_ONE) || (a == `OFS_CTRL_TWO) || (a == `OFS_DATA) ||
             (a == `OFS_STATUS) || (a == `OFS_SLAVE_ADDR);
  endfunction

  // own write address or enabled general call
  function automatic logic addr_match(input logic [7:0] b, input logic [6:0] own, input logic general_call_enable);
    addr_match = (general_call_enable && b == `GEN_CALL_ADDR) || (b[7:1] == own && !b[0]);
  endfunction

  line_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .view(lines)
  );

  ////////////////////////////////////////////////////////////////////////////
  // apb slave
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);
  assign prdata = prdata_reg;

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel && !penable) begin
      unique case (paddr)
        `OFS_CTRL_ONE: prdata_reg <= {26'h0, port_en_reg, clk_rel_reg, master_reg, 3'h0};
        `OFS_CTRL_TWO: prdata_reg <= {24'h0, c2_reg};
        `OFS_DATA: prdata_reg <= {24'h0, rx_byte_reg};
        `OFS_STATUS: prdata_reg <= {28'h0, full_reg, running, gc_reg, event_reg};
        `OFS_SLAVE_ADDR: prdata_reg <= {25'h0, slave_addr_reg};
        default: prdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // first control register; hardware clears clock release on a stretch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_en_reg <= 1'b0;
      master_reg <= 1'b0;
      clk_rel_reg <= 1'b0;
    end else begin
      if (stretch_start) begin
        clk_rel_reg <= 1'b0;
      end
      if (wr && paddr == `OFS_CTRL_ONE) begin
        port_en_reg <= pwdata[`C1_PORT_EN];
        master_reg <= pwdata[`C1_MASTER];
        clk_rel_reg <= pwdata[`C1_CLK_REL];
      end
    end
  end

  assign master_en = port_en_reg && master_reg;
  assign slave_en = port_en_reg && !master_reg;

  // second control register; command bits self clear when done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c2_reg <= `CTRL_RESET;
    end else begin
      if (m_done) begin
        unique case (m_state_reg)
          M_START: c2_reg[`C2_SEN] <= 1'b0;
          M_RSTART: c2_reg[`C2_REPEATED_START_ENABLE] <= 1'b0;
          M_STOP: c2_reg[`C2_PEN] <= 1'b0;
          M_RX: c2_reg[`C2_RECEIVE_ENABLE_FIELD] <= 1'b0;
          M_ACK: c2_reg[`C2_ACK_SEQUENCE_ENABLE] <= 1'b0;
          default: ;
        endcase
      end
      if (step && m_state_reg == M_TX && phase_reg == 2'h2 && bit_reg == `ACK_SLOT) begin
        c2_reg[`C2_ACK_STATUS] <= lines.sda;
      end
      if (wr && paddr == `OFS_CTRL_TWO) begin
        c2_reg[`C2_GENERAL_CALL_ENABLE] <= pwdata[`C2_GENERAL_CALL_ENABLE];
        c2_reg[5:0] <= pwdata[5:0]; // ack status kept
      end
    end
  end

  // data, status and slave address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_byte_reg <= 8'h00;
      rx_byte_reg <= 8'h00;
      slave_addr_reg <= `ADDR_RESET;
      tx_pend_reg <= 1'b0;
      event_reg <= 1'b0;
      gc_reg <= 1'b0;
      full_reg <= 1'b0;
    end else begin
      if (wr && paddr == `OFS_DATA) begin
        tx_byte_reg <= pwdata[7:0];
      end
      if (wr && paddr == `OFS_SLAVE_ADDR) begin
        slave_addr_reg <= pwdata[6:0];
      end
      tx_pend_reg <= (wr && paddr == `OFS_DATA && master_en) ||
                     (tx_pend_reg && master_en && !(launch_ok && launch_state == M_TX));
      if (m_done && m_state_reg == M_RX) begin
        rx_byte_reg <= rx_shift_reg;
      end else if (s_load) begin
        rx_byte_reg <= s_shift_reg;
      end
      // sticky flags: a set in the clearing cycle wins
      event_reg <= m_done || s_event || (event_reg && !(wr && paddr == `OFS_STATUS && pwdata[`ST_EVENT]));
      gc_reg <= (s_event && s_state_reg == S_ADDR && s_shift_reg == `GEN_CALL_ADDR) ||
                (gc_reg && !(wr && paddr == `OFS_STATUS && pwdata[`ST_GC]));
      full_reg <= (m_done && m_state_reg == M_RX) || s_load || (full_reg && !(rd && paddr == `OFS_DATA));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // quarter-bit divider, runs only while a sequence is active
  assign running = m_state_reg != M_IDLE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qcnt_reg <= 12'h000;
    end else if (!running || qcnt_reg == 12'h000) begin
      qcnt_reg <= QLOAD;
    end else begin
      qcnt_reg <= qcnt_reg - 12'h001;
    end
  end

  // waits in phase 2 while a slave stretches scl
  assign step = running && qcnt_reg == 12'h000 && !(phase_reg == 2'h2 && !lines.scl);

  // last quarter of each sequence
  always_comb begin
    unique case (m_state_reg)
      M_START, M_STOP: m_last = phase_reg == 2'h2;
      M_RSTART, M_ACK: m_last = phase_reg == 2'h3;
      M_TX: m_last = phase_reg == 2'h3 && bit_reg == `ACK_SLOT;
      M_RX: m_last = phase_reg == 2'h3 && bit_reg == `LAST_DATA_BIT;
      default: m_last = 1'b0;
    endcase
  end
  assign m_done = step && m_last;

  // launch priority among pending commands
  always_comb begin
    launch_state = M_IDLE;
    if (c2_reg[`C2_SEN]) begin
      launch_state = M_START;
    end else if (c2_reg[`C2_REPEATED_START_ENABLE]) begin
      launch_state = M_RSTART;
    end else if (c2_reg[`C2_PEN]) begin
      launch_state = M_STOP;
    end else if (c2_reg[`C2_RECEIVE_ENABLE_FIELD]) begin
      launch_state = M_RX;
    end else if (c2_reg[`C2_ACK_SEQUENCE_ENABLE]) begin
      launch_state = M_ACK;
    end else if (tx_pend_reg) begin
      launch_state = M_TX;
    end
  end
  assign launch_ok = master_en && !running;

  // master sequencer state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_state_reg <= M_IDLE;
      phase_reg <= 2'h0;
      bit_reg <= 4'h0;
    end else if (!master_en) begin
      m_state_reg <= M_IDLE;
      phase_reg <= 2'h0;
      bit_reg <= 4'h0;
    end else if (!running) begin
      m_state_reg <= launch_state;
      phase_reg <= 2'h0;
      bit_reg <= 4'h0;
    end else if (step) begin
      phase_reg <= phase_reg + 2'h1;
      if (phase_reg == 2'h3) begin
        bit_reg <= bit_reg + 4'h1;
      end
      if (m_last) begin
        m_state_reg <= M_IDLE;
      end
    end
  end

  // master line drive and shifting, one quarter at a time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_drv_reg <= 1'b0;
      sda_drv_reg <= 1'b0;
      tx_shift_reg <= 8'h00;
      rx_shift_reg <= 8'h00;
    end else if (!master_en) begin
      scl_drv_reg <= 1'b0;
      sda_drv_reg <= 1'b0;
    end else if (launch_ok && launch_state == M_TX) begin
      tx_shift_reg <= tx_byte_reg;
    end else if (step) begin
      unique case (m_state_reg)
        M_START: begin
          if (phase_reg == 2'h1) sda_drv_reg <= 1'b1;
          if (phase_reg == 2'h2) scl_drv_reg <= 1'b1;
        end
        M_RSTART: begin
          if (phase_reg == 2'h0) sda_drv_reg <= 1'b0;
          if (phase_reg == 2'h1) scl_drv_reg <= 1'b0;
          if (phase_reg == 2'h2) sda_drv_reg <= 1'b1;
          if (phase_reg == 2'h3) scl_drv_reg <= 1'b1;
        end
        M_STOP: begin
          if (phase_reg == 2'h0) sda_drv_reg <= 1'b1;
          if (phase_reg == 2'h1) scl_drv_reg <= 1'b0;
          if (phase_reg == 2'h2) sda_drv_reg <= 1'b0;
        end
        M_TX: begin
          if (phase_reg == 2'h0) sda_drv_reg <= (bit_reg != `ACK_SLOT) && !tx_shift_reg[7];
          if (phase_reg == 2'h1) scl_drv_reg <= 1'b0;
          if (phase_reg == 2'h3) begin
            scl_drv_reg <= 1'b1;
            tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
          end
        end
        M_RX: begin
          if (phase_reg == 2'h0) sda_drv_reg <= 1'b0;
          if (phase_reg == 2'h1) scl_drv_reg <= 1'b0;
          if (phase_reg == 2'h2) rx_shift_reg <= {rx_shift_reg[6:0], lines.sda};
          if (phase_reg == 2'h3) scl_drv_reg <= 1'b1;
        end
        M_ACK: begin
          if (phase_reg == 2'h0) sda_drv_reg <= !c2_reg[`C2_ACK_DATA_VALUE];
          if (phase_reg == 2'h1) scl_drv_reg <= 1'b0;
          if (phase_reg == 2'h3) scl_drv_reg <= 1'b1;
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // slave receive: decide on the falling edge of the eighth clock
  assign s_decide = slave_en && lines.scl_fall && s_bits_reg == `ACK_SLOT;
  assign s_hit = s_state_reg == S_ADDR && addr_match(s_shift_reg, slave_addr_reg, c2_reg[`C2_GENERAL_CALL_ENABLE]);
  assign s_load = s_decide && s_state_reg == S_DATA && !full_reg;
  assign s_event = s_decide && (s_hit || s_load);
  assign stretch_start = slave_en && lines.scl_fall && s_bits_reg == `SLAVE_ACK_DONE &&
                         s_state_reg == S_DATA && s_took_reg && c2_reg[`C2_SEN];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_state_reg <= S_IDLE;
      s_bits_reg <= 4'h0;
      s_shift_reg <= 8'h00;
      s_ack_reg <= 1'b0;
      s_took_reg <= 1'b0;
    end else if (!slave_en) begin
      s_state_reg <= S_IDLE;
      s_bits_reg <= 4'h0;
      s_ack_reg <= 1'b0;
      s_took_reg <= 1'b0;
    end else if (lines.sda_fall && lines.scl) begin
      s_state_reg <= S_ADDR;
      s_bits_reg <= 4'h0;
      s_ack_reg <= 1'b0;
    end else if (lines.sda_rise && lines.scl) begin
      s_state_reg <= S_IDLE;
      s_ack_reg <= 1'b0;
    end else if (s_state_reg != S_IDLE) begin
      if (lines.scl_rise) begin
        s_shift_reg <= {s_shift_reg[6:0], lines.sda};
        s_bits_reg <= s_bits_reg + 4'h1;
      end
      if (s_decide) begin
        s_ack_reg <= s_hit || s_load;
        s_took_reg <= s_load;
        if (s_state_reg == S_ADDR) begin
          s_state_reg <= s_hit ? S_DATA : S_IGNORE;
        end
      end
      if (lines.scl_fall && s_bits_reg == `SLAVE_ACK_DONE) begin
        s_ack_reg <= 1'b0;
        s_bits_reg <= 4'h0;
      end
    end
  end

  // clock hold after a received data byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stretch_reg <= 1'b0;
    end else begin
      stretch_reg <= stretch_start || (stretch_reg && slave_en && !clk_rel_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // open-drain pins: only ever pull low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = scl_drv_reg || stretch_reg;
  assign sda_oe = sda_drv_reg || s_ack_reg;
  assign serial_event = event_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  AST_GC_EVENT: assert property (@(posedge pclk) disable iff (!presetn)
    s_decide && s_state_reg == S_ADDR && s_shift_reg == `GEN_CALL_ADDR && c2_reg[`C2_GENERAL_CALL_ENABLE]
    |=> event_reg && gc_reg && sda_oe)
    else $error("general call not answered");
  AST_GC_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    s_decide && s_state_reg == S_ADDR && s_shift_reg == `GEN_CALL_ADDR && !c2_reg[`C2_GENERAL_CALL_ENABLE] &&
    slave_addr_reg != `ADDR_RESET |=> !s_ack_reg && !$rose(gc_reg))
    else $error("disabled general call acknowledged");
  AST_ACK_STATUS: assert property (@(posedge pclk) disable iff (!presetn)
    step && m_state_reg == M_TX && phase_reg == 2'h2 && bit_reg == `ACK_SLOT
    |=> c2_reg[`C2_ACK_STATUS] == $past(lines.sda))
    else $error("ack status not taken from slot");
  AST_ACK_DATA_VALUE: assert property (@(posedge pclk) disable iff (!presetn)
    m_state_reg == M_ACK && phase_reg != 2'h0 |-> sda_oe == !c2_reg[`C2_ACK_DATA_VALUE])
    else $error("ack slot level wrong");
  AST_ACK_SEQUENCE_ENABLE_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    m_done && master_en && m_state_reg == M_ACK && !(wr && paddr == `OFS_CTRL_TWO)
    |=> !c2_reg[`C2_ACK_SEQUENCE_ENABLE] && !running && scl_drv_reg)
    else $error("ack sequence not cleared");
  AST_RX_DONE: assert property (@(posedge pclk) disable iff (!presetn)
    m_done && m_state_reg == M_RX |=> full_reg && rx_byte_reg == $past(rx_shift_reg))
    else $error("received byte not stored");
  AST_STOP: assert property (@(posedge pclk) disable iff (!presetn)
    m_done && m_state_reg == M_STOP |=> !sda_drv_reg && !scl_drv_reg && !running)
    else $error("stop left lines driven");
  AST_RSTART: assert property (@(posedge pclk) disable iff (!presetn)
    m_done && m_state_reg == M_RSTART |=> sda_drv_reg && scl_drv_reg)
    else $error("repeated start ended wrong");
  AST_START: assert property (@(posedge pclk) disable iff (!presetn)
    step && m_state_reg == M_START && phase_reg == 2'h1 |=> sda_drv_reg && !scl_drv_reg)
    else $error("start drove scl before sda");
  AST_STRETCH: assert property (@(posedge pclk) disable iff (!presetn)
    stretch_start && !(wr && paddr == `OFS_CTRL_ONE) |=> scl_oe && !clk_rel_reg)
    else $error("stretch not held");
  AST_PORT_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    !port_en_reg |=> !running && !s_ack_reg)
    else $error("engine active with port off");
  AST_ACK_STATUS_WR: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == `OFS_CTRL_TWO && !(step && m_state_reg == M_TX) |=> $stable(c2_reg[`C2_ACK_STATUS]))
    else $error("software changed ack status");
endmodule
`default_nettype wire

/* core/line_sync.sv */
// Purpose: bring scl and sda into the pclk domain and find their edges
// Assumes: lines come straight from pins
// Notes: first stage feeds only the second stage
`default_nettype none
module line_sync
  import i2c_seq_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // raw pins
  input wire logic scl_in,
  input wire logic sda_in,
  // synchronised view
  output var line_view_t view
);
  logic [1:0] meta_reg;
  logic [1:0] sync_reg;
  logic [1:0] last_reg;

  // two stages, then one for edge finding; idle bus reads high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= 2'h3;
      sync_reg <= 2'h3;
      last_reg <= 2'h3;
    end else begin
      meta_reg <= {scl_in, sda_in};
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  // edges from stable stages only
  assign view = '{
    scl: sync_reg[1],
    sda: sync_reg[0],
    scl_rise: sync_reg[1] & ~last_reg[1],
    scl_fall: ~sync_reg[1] & last_reg[1],
    sda_rise: sync_reg[0] & ~last_reg[0],
    sda_fall: ~sync_reg[0] & last_reg[0]
  };
endmodule
`default_nettype wire

/* verification/far_slave.sv */
// Purpose: far side slave that answers bytes in the ack slot
// Assumes: both lines pulled up, open drain
// Notes: ack_en picks acknowledge or no acknowledge
`default_nettype none
module far_slave (
  // bus lines
  input wire logic scl,
  input wire logic sda,
  // control
  input wire logic ack_en,
  // drive
  output logic sda_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  int bits = 0;
  initial sda_oe = 1'b0;
  // start restarts the count
  always @(negedge sda) begin
    if (scl) bits = 0;
  end
  // count clocks, wrap after the ack clock
  always @(posedge scl) begin
    bits = (bits == 9) ? 1 : bits + 1;
  end
  // pull sda low only through the ack slot
  always @(negedge scl) begin
    sda_oe <= (bits == 8) && ack_en;
  end
endmodule
`default_nettype wire

/* verification/i2c_sequence_control_fields_tb.sv */
// Purpose: bench for the sequence control fields, master mode and slave receive
// Assumes: short quarters of 4 clocks
// Notes: released lines read high through the pull-ups
`default_nettype none
module i2c_sequence_control_fields_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slv;
  logic scl_oe, sda_oe, ps_oe, serial_event, ack_en, m_scl_oe, m_sda_oe;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  wire logic scl = !(scl_oe || m_scl_oe);
  wire logic sda = !(sda_oe || ps_oe || m_sda_oe);
  int err_count = 0;
  int n_tests = 0;

  ////////////////////////////////////////////////////////////
  // design and far side
  i2c_sequence_control_fields #(.QUARTER_CYCLES(4)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_in(scl), .scl_o(),
    .scl_oe(scl_oe), .sda_in(sda), .sda_o(), .sda_oe(sda_oe),
    .serial_event(serial_event)
  );
  far_slave peer (.scl(scl), .sda(sda), .ack_en(ack_en), .sda_oe(ps_oe));

  // clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////
  // one apb transfer, waits for pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask

  // read until the masked bits clear
  task automatic poll(input logic [7:0] a, input logic [31:0] m);
    for (int i = 0; i < 300; i++) begin
      apb(1'b0, a, 32'h0);
      if ((rd & m) === 32'h0) return;
    end
    chk(rd & m, 32'h0, "wait ran out");
  endtask

  // send a byte, far side acks or not
  task automatic send(input logic [7:0] b, input logic en);
    ack_en <= en;
    apb(1'b1, 8'h08, {24'h0, b});
    repeat (3) @(posedge pclk);
    poll(8'h0C, 32'h4);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd & 32'h40, en ? 32'h0 : 32'h40, "ack status");
  endtask

  // ack sequence, sda level mid sequence
  task automatic ack_case(input logic dt);
    apb(1'b1, 8'h04, dt ? 32'h30 : 32'h10);
    repeat (6) @(posedge pclk);
    #1;
    chk({31'h0, sda_oe}, {31'h0, !dt}, "ack slot level");
    poll(8'h04, 32'h10);
  endtask

  // far master bit: data while scl low, then one clock
  task automatic put_bit(input logic b);
    m_sda_oe <= !b;
    repeat (4) @(posedge pclk);
    m_scl_oe <= 1'b0;
    repeat (4) @(posedge pclk);
    m_scl_oe <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask

  // far master byte, msb first, no ack clock
  task automatic put_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) put_bit(b[i]);
  endtask

  // verdict
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    #200us;
    err_count++;
    close_out();
  end

  ////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ack_en = 1'b1;
    m_scl_oe = 1'b0;
    m_sda_oe = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0, "ctrl two reset");
    apb(1'b1, 8'h04, 32'hFF);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'hBF, "ctrl two readback");
    repeat (20) @(posedge pclk);
    chk({30'h0, scl_oe, sda_oe}, 32'h0, "lines moved with port off");
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk({31'h0, slv}, 32'h1, "unmapped read");
    apb(1'b1, 8'h00, 32'h28);
    apb(1'b1, 8'h04, 32'h01);
    poll(8'h04, 32'h01);
    chk({30'h0, scl_oe, sda_oe}, 32'h3, "start");
    chk({31'h0, serial_event}, 32'h1, "event after start");
    apb(1'b1, 8'h0C, 32'h1);
    send(8'hA4, 1'b1);
    send(8'h5B, 1'b0);
    apb(1'b1, 8'h04, 32'h08);
    poll(8'h04, 32'h08);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'hFF, "received byte");
    ack_case(1'b0);
    ack_case(1'b1);
    apb(1'b1, 8'h04, 32'h02);
    poll(8'h04, 32'h02);
    chk({30'h0, scl_oe, sda_oe}, 32'h3, "repeated start");
    apb(1'b1, 8'h04, 32'h04);
    poll(8'h04, 32'h04);
    chk({30'h0, scl_oe, sda_oe}, 32'h0, "stop");
    // slave receive: general call, then a stretched data byte
    apb(1'b1, 8'h00, 32'h20);
    apb(1'b1, 8'h10, 32'h2A);
    apb(1'b1, 8'h04, 32'h81);
    m_sda_oe <= 1'b1;
    repeat (4) @(posedge pclk);
    m_scl_oe <= 1'b1;
    put_byte(8'h00);
    chk({31'h0, sda_oe}, 32'h1, "general call ack");
    put_bit(1'b1);
    put_byte(8'h3C);
    put_bit(1'b1);
    chk({31'h0, scl_oe}, 32'h1, "slave stretch");
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'hB, "slave status");
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h3C, "slave byte");
    apb(1'b1, 8'h00, 32'h30);
    repeat (2) @(posedge pclk);
    chk({31'h0, scl_oe}, 32'h0, "stretch released");
    close_out();
  end
endmodule
`default_nettype wire
